// file: rtl/tsh_host_if.sv
`timescale 1ns/10ps
module tsh_host_if
  import tsh_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int ID_W = 5
) (
  // clock, phase and reset
  input wire logic clk_in,
  input wire logic phase_select_n_in,
  input wire logic rstn_in,
  // instruction and shared data bus
  input wire logic [INSTR_W-1:0] instr_in,
  input wire logic instr_valid_in,
  input wire logic [DQ_W-1:0] dq_in,
  output logic [DQ_W-1:0] dq_out,
  output logic dq_oe_out,
  // handshake and search result
  output logic read_ack_out,
  output logic read_ack_oe_out,
  output logic burst_end_out,
  output logic burst_end_oe_out,
  output logic match_win_flag_out,
  output logic match_win_valid_out,
  // cascade
  input wire logic [ID_W-1:0] device_id_in,
  input wire logic last_mem_driver_bit_in,
  input wire logic cascade_hit_in,
  input wire logic full_chain_in,
  output logic local_hit_out,
  output logic local_full_out,
  output logic table_full_out,
  // associated data memory
  output tsh_sram_s sram_out,
  output logic sram_ctl_oe_out,
  output logic sram_oe_n_oe_out
);

  localparam int AW = $clog2(DEPTH);
  localparam int LAST = SEARCH_LAT_CYC - 1;

  // ****************************************
  // decode
  // ****************************************
  function automatic logic [AW:0] first_set(input logic [DEPTH-1:0] v);
    first_set = '0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = {1'b1, AW'(i)};
      end
    end
  endfunction

  logic tick;
  logic cmd;
  tsh_op_e op;
  logic [1:0] tgt;
  logic burst;
  logic [LEN_W-1:0] len;

  // core clock is the double rate clock qualified by the low phase
  assign tick = ~phase_select_n_in;
  assign cmd = tick & instr_valid_in;
  assign op = tsh_op_e'(instr_in[OP_MSB:OP_LSB]);
  assign tgt = instr_in[TGT_MSB:TGT_LSB];
  assign burst = instr_in[BURST_BIT];
  assign len = instr_in[LEN_MSB:LEN_LSB];

  // ****************************************
  // entry array and ternary compare
  // ****************************************
  logic [DQ_W-1:0] data_mem [DEPTH];
  logic [DQ_W-1:0] mask_mem [DEPTH];
  logic [DQ_W-1:0] key_reg;
  logic [DEPTH-1:0] hit_vec;
  logic [DEPTH-1:0] occ_vec;
  logic [AW:0] hit_sel;
  logic [AW:0] free_sel;

  for (genvar g = 0; g < DEPTH; g++) begin : g_cmp
    assign occ_vec[g] = data_mem[g][OCC_BIT];
    // mask bit high enables compare; low is don't care
    assign hit_vec[g] = occ_vec[g]
                        & ~|((data_mem[g] ^ dq_in) & mask_mem[g]);
  end

  assign hit_sel = first_set(hit_vec);
  assign free_sel = first_set(~occ_vec);

  // ****************************************
  // command sequencer
  // ****************************************
  tsh_state_e state_reg;
  logic [AW-1:0] addr_reg;
  logic [LEN_W-1:0] left_reg;
  logic [1:0] tgt_reg;
  logic burst_reg;
  logic [LAT_W-1:0] wait_reg;
  logic last_mem_reg;

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      state_reg <= ST_IDLE;
      addr_reg <= '0;
      left_reg <= '0;
      tgt_reg <= TGT_DATA;
      burst_reg <= 1'b0;
      wait_reg <= '0;
    end else if (tick) begin
      unique case (state_reg)
        ST_IDLE: begin
          if (cmd && tgt != TGT_SRAM
              && (op == OP_DIRECT_WRITE || op == OP_DIRECT_READ)) begin
            addr_reg <= dq_in[AW-1:0];
            tgt_reg <= tgt;
            burst_reg <= burst;
            left_reg <= burst ? len : '0;
            wait_reg <= READ_LAT_CYC - 3'h1;
            state_reg <= (op == OP_DIRECT_WRITE) ? ST_WDATA : ST_RWAIT;
          end else if (cmd && tgt == TGT_SRAM && op == OP_DIRECT_READ
                       && last_mem_reg) begin
            // only the last driver acks, so peers never fight on the pin
            tgt_reg <= TGT_SRAM;
            burst_reg <= 1'b0;
            left_reg <= '0;
            wait_reg <= SRAM_RD_LAT_CYC - 3'h1;
            state_reg <= ST_RWAIT;
          end
        end
        ST_WDATA: begin
          addr_reg <= addr_reg + 1'b1;
          left_reg <= left_reg - 1'b1;
          if (left_reg == '0) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_RWAIT: begin
          wait_reg <= wait_reg - 1'b1;
          if (wait_reg == '0) begin
            state_reg <= (left_reg == '0) ? ST_IDLE : ST_RDATA;
          end
        end
        ST_RDATA: begin
          addr_reg <= addr_reg + 1'b1;
          left_reg <= left_reg - 1'b1;
          if (left_reg == LEN_W'(1)) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // strap caught while reset is held, clocked
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      last_mem_reg <= last_mem_driver_bit_in;
    end
  end

  // ****************************************
  // storage writes and learn
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        data_mem[i] <= '0;
        mask_mem[i] <= '0;
      end
      key_reg <= '0;
    end else if (tick) begin
      if (state_reg == ST_WDATA) begin
        if (tgt_reg == TGT_MASK) begin
          mask_mem[addr_reg] <= dq_in;
        end else begin
          data_mem[addr_reg] <= dq_in;
        end
      end else if (cmd && op == OP_SEARCH) begin
        key_reg <= dq_in;
      end else if (cmd && op == OP_LEARN && free_sel[AW]) begin
        // learned entry is exact match on the last key, marked occupied
        data_mem[free_sel[AW-1:0]] <= key_reg | DQ_W'(1) << OCC_BIT;
        mask_mem[free_sel[AW-1:0]] <= '1;
      end
    end
  end

  // ****************************************
  // read data, ack and burst end
  // ****************************************
  logic rd_go;
  logic rd_last;
  logic [AW-1:0] rd_addr;
  logic wr_last;

  assign rd_go = (state_reg == ST_RWAIT && wait_reg == '0)
                 || state_reg == ST_RDATA;
  assign rd_addr = (state_reg == ST_RDATA) ? addr_reg + 1'b1 : addr_reg;
  assign rd_last = (state_reg == ST_RDATA) ? (left_reg == LEN_W'(1))
                                           : (left_reg == '0);
  assign wr_last = state_reg == ST_WDATA && left_reg == '0;

  logic [DQ_W-1:0] dq_reg;
  logic dq_oe_reg;
  logic ack_reg;
  logic bend_reg;

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      dq_reg <= '0;
      dq_oe_reg <= 1'b0;
      ack_reg <= 1'b0;
      bend_reg <= 1'b0;
    end else if (tick) begin
      ack_reg <= rd_go;
      dq_oe_reg <= rd_go && tgt_reg != TGT_SRAM;
      dq_reg <= (tgt_reg == TGT_MASK) ? mask_mem[rd_addr]
                                      : data_mem[rd_addr];
      bend_reg <= burst_reg && ((rd_go && rd_last) || wr_last);
    end
  end

  // pull-downs hold these low while released
  assign dq_out = dq_reg;
  assign dq_oe_out = dq_oe_reg;
  assign read_ack_out = ack_reg;
  assign read_ack_oe_out = ack_reg;
  assign burst_end_out = bend_reg;
  assign burst_end_oe_out = bend_reg;

  // ****************************************
  // search pipeline and cascade arbitration
  // ****************************************
  logic [SEARCH_LAT_CYC-1:0] pipe_v;
  logic [SEARCH_LAT_CYC-1:0] pipe_h;
  logic [AW-1:0] pipe_i [SEARCH_LAT_CYC];
  logic lhit_reg;

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      pipe_v <= '0;
      pipe_h <= '0;
      for (int s = 0; s < SEARCH_LAT_CYC; s++) begin
        pipe_i[s] <= '0;
      end
      lhit_reg <= 1'b0;
    end else if (tick) begin
      pipe_v[0] <= cmd && op == OP_SEARCH;
      pipe_h[0] <= cmd && op == OP_SEARCH && hit_sel[AW];
      pipe_i[0] <= hit_sel[AW-1:0];
      for (int s = 1; s < SEARCH_LAT_CYC; s++) begin
        pipe_v[s] <= pipe_v[s-1];
        pipe_h[s] <= pipe_h[s-1];
        pipe_i[s] <= pipe_i[s-1];
      end
      lhit_reg <= pipe_h[0];
    end
  end

  assign local_hit_out = lhit_reg;

  logic res_v;
  logic res_win;
  logic any_hit;
  logic dir_sram;
  logic dir_rd;

  assign res_v = pipe_v[LAST];
  // a peer nearer address zero hitting suppresses this device
  assign res_win = res_v & pipe_h[LAST] & ~cascade_hit_in;
  assign any_hit = res_v & (pipe_h[LAST] | cascade_hit_in);
  // direct accesses are broadcast; the last driver runs the memory
  assign dir_sram = last_mem_reg && state_reg == ST_IDLE && cmd
                    && tgt == TGT_SRAM
                    && (op == OP_DIRECT_READ || op == OP_DIRECT_WRITE);
  assign dir_rd = dir_sram && op == OP_DIRECT_READ;

  // ****************************************
  // result flags and memory control
  // ****************************************
  logic win_flag_reg;
  logic win_valid_reg;
  tsh_sram_s sram_reg;
  logic ctl_oe_reg;
  logic lfull_reg;
  logic tfull_reg;

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      win_flag_reg <= 1'b0;
      win_valid_reg <= 1'b0;
    end else if (tick) begin
      win_valid_reg <= res_v;
      win_flag_reg <= res_win;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      sram_reg <= SRAM_IDLE;
      ctl_oe_reg <= 1'b0;
    end else if (tick) begin
      sram_reg.oe_n <= ~(any_hit | dir_rd);
      // idle control is held high by the last driver unless a peer wins
      ctl_oe_reg <= res_win
                    | (last_mem_reg & ~(res_v & cascade_hit_in));
      if (res_win) begin
        sram_reg.addr <= ASSOC_MEM_ADDR_W'({device_id_in, pipe_i[LAST]});
        sram_reg.ce_n <= 1'b0;
        sram_reg.we_n <= 1'b1;
        sram_reg.ale_n <= 1'b0;
      end else if (dir_sram && !res_v) begin
        sram_reg.addr <= dq_in[ASSOC_MEM_ADDR_W-1:0];
        sram_reg.ce_n <= 1'b0;
        sram_reg.we_n <= ~(op == OP_DIRECT_WRITE);
        sram_reg.ale_n <= 1'b0;
      end else begin
        sram_reg.ce_n <= 1'b1;
        sram_reg.we_n <= 1'b1;
        sram_reg.ale_n <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      lfull_reg <= 1'b0;
      tfull_reg <= 1'b0;
    end else if (tick) begin
      lfull_reg <= &occ_vec;
      tfull_reg <= (&occ_vec) & full_chain_in;
    end
  end

  assign match_win_flag_out = win_flag_reg;
  assign match_win_valid_out = win_valid_reg;
  assign sram_out = sram_reg;
  assign sram_ctl_oe_out = ctl_oe_reg;
  assign sram_oe_n_oe_out = last_mem_reg;
  assign local_full_out = lfull_reg;
  assign table_full_out = tfull_reg;

endmodule // tsh_host_if

// file: rtl/tsh_pkg.sv
// Function
// - opcode in low two bits, parameters above
// - opcodes: read, write, search, learn
// - instruction taken only while valid high
// - shared bus carries address, data, keys
// - entry is data plus mask, ternary compare
// - lowest matching address wins locally
// - winner nearest cascade address zero drives
// - search result and sram cycles pipelined
// - entry bit zero marks occupied
// - full flag only when all entries occupied
// - inputs sampled on double rate clock edge
// - outputs launched only while phase low
// - phase input derives the core clock
// - reset low returns logic to initial state
// - read ack marks valid read data
// - burst end marks final burst transfer
// - win flag only for global winner
// - win valid qualifies the win flag
// - drive 22-bit associated memory address
// - one device drives chip and write enable
// - only last driver drives output enable
// - address latch low while address valid
// - latencies counted in core clock cycles
package tsh_pkg;

  // ****************************************
  // bus widths and instruction fields
  // ****************************************
  localparam int INSTR_W = 9;
  localparam int DQ_W = 68;
  localparam int ASSOC_MEM_ADDR_W = 22;
  localparam int OP_LSB = 0;
  localparam int OP_MSB = 1;
  localparam int TGT_LSB = 2;
  localparam int TGT_MSB = 3;
  localparam int BURST_BIT = 4;
  localparam int LEN_LSB = 5;
  localparam int LEN_MSB = 8;
  localparam int LEN_W = LEN_MSB - LEN_LSB + 1;
  localparam int OCC_BIT = 0;

  // ****************************************
  // target codes and latencies in core cycles
  // ****************************************
  localparam logic [1:0] TGT_DATA = 2'h0;
  localparam logic [1:0] TGT_MASK = 2'h1;
  localparam logic [1:0] TGT_SRAM = 2'h2;
  localparam int LAT_W = 3;
  localparam logic [LAT_W-1:0] READ_LAT_CYC = 3'h2;
  localparam logic [LAT_W-1:0] SRAM_RD_LAT_CYC = 3'h3;
  localparam int SEARCH_LAT_CYC = 4;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    OP_DIRECT_READ = 2'b00,
    OP_DIRECT_WRITE = 2'b01,
    OP_SEARCH = 2'b10,
    OP_LEARN = 2'b11
  } tsh_op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WDATA = 2'b01,
    ST_RWAIT = 2'b10,
    ST_RDATA = 2'b11
  } tsh_state_e;

  typedef struct packed {
    logic [ASSOC_MEM_ADDR_W-1:0] addr;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic ale_n;
  } tsh_sram_s;

  localparam tsh_sram_s SRAM_IDLE = '{addr: '0, ce_n: 1'b1, we_n: 1'b1,
                                     oe_n: 1'b1, ale_n: 1'b1};

endpackage : tsh_pkg

// file: testbench/tsh_host_if_assertions.sv
`timescale 1ns/10ps
module tsh_host_if_assertions
  import tsh_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int ID_W = 5
) (
  // clock, phase, reset
  input wire logic clk_in,
  input wire logic phase_select_n_in,
  input wire logic rstn_in,
  // host side
  input wire logic [INSTR_W-1:0] instr_in,
  input wire logic instr_valid_in,
  input wire logic [DQ_W-1:0] dq_in,
  input wire logic dq_oe_out,
  input wire logic read_ack_out,
  input wire logic read_ack_oe_out,
  input wire logic burst_end_out,
  input wire logic burst_end_oe_out,
  input wire logic match_win_flag_out,
  input wire logic match_win_valid_out,
  // cascade and memory
  input wire logic last_mem_driver_bit_in,
  input wire logic local_full_out,
  input wire logic table_full_out,
  input wire tsh_sram_s sram_out,
  input wire logic sram_ctl_oe_out,
  input wire logic sram_oe_n_oe_out
);
  // ****************************************
  // request decode at a tick
  // ****************************************
  wire logic go = !phase_select_n_in && instr_valid_in;
  wire logic [1:0] op = instr_in[OP_MSB:OP_LSB];
  wire logic [1:0] tg = instr_in[TGT_MSB:TGT_LSB];
  wire logic sr = go && tg == TGT_SRAM && last_mem_driver_bit_in;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  AST_STILL_OFF_TICK: assert property (phase_select_n_in |=>
    $stable({dq_oe_out, read_ack_out, burst_end_out, match_win_flag_out,
    match_win_valid_out, table_full_out, sram_out}))
    else $error("output moved between ticks");
  AST_READ_ACK: assert property (go && op == 2'h0 && tg < 2'h2
    && !dq_oe_out && !read_ack_out |-> ##5 (read_ack_out && dq_oe_out))
    else $error("read ack late or missing");
  AST_SRAM_RD_ACK: assert property (sr && op == 2'h0
    |-> ##7 (read_ack_out && !dq_oe_out))
    else $error("memory read ack wrong");
  AST_SRAM_WR: assert property (sr && op == 2'h1
    && !match_win_valid_out |-> ##1 (!sram_out.we_n && !sram_out.ce_n
    && sram_out.addr == $past(dq_in[ASSOC_MEM_ADDR_W-1:0]))
    ##1 !sram_out.we_n ##1 sram_out.we_n)
    else $error("memory write strobe wrong");
  AST_WIN_LAT: assert property (go && op == 2'h2
    |-> ##9 match_win_valid_out) else $error("search result late");
  AST_WIN_QUAL: assert property (match_win_flag_out
    |-> match_win_valid_out) else $error("flag without valid");
  AST_BURST_PULSE: assert property ($rose(burst_end_out)
    |=> burst_end_out ##1 !burst_end_out) else $error("burst end width");
  AST_PIN_RELEASE: assert property (
    (read_ack_oe_out == read_ack_out)
    && (burst_end_oe_out == burst_end_out)) else $error("pin not released");
  AST_LAST_DRIVER: assert property (sram_oe_n_oe_out
    == last_mem_driver_bit_in) else $error("output enable driver wrong");
  AST_FULL: assert property (table_full_out |-> local_full_out)
    else $error("full without local full");
  AST_LATCH: assert property (!sram_out.ale_n
    |-> !sram_out.ce_n && sram_ctl_oe_out) else $error("latch low idle");
  AST_RESET: assert property (disable iff (1'b0) !rstn_in |=>
    !read_ack_out && !match_win_valid_out && !dq_oe_out && sram_out.ce_n)
    else $error("reset state wrong");
endmodule // tsh_host_if_assertions

// file: testbench/tsh_host_model.sv
`timescale 1ns/10ps
module tsh_host_model
  import tsh_pkg::*;
(
  // clock
  input wire logic clk_in,
  // host drive
  output logic phase_select_n_out,
  output logic [INSTR_W-1:0] instr_out,
  output logic instr_valid_out,
  output logic [DQ_W-1:0] dq_out
);
  initial begin
    phase_select_n_out = 1'b1;
    instr_out = '0;
    instr_valid_out = 1'b0;
    dq_out = '0;
  end
  // one flip per clock: a core cycle is two clocks
  always @(negedge clk_in) begin
    phase_select_n_out <= ~phase_select_n_out;
  end

  // ****************************************
  // one word, held across the next tick
  // ****************************************
  task automatic send(input logic v, input logic [INSTR_W-1:0] i,
                      input logic [DQ_W-1:0] d);
    @(posedge clk_in);
    while (phase_select_n_out !== 1'b1) @(posedge clk_in);
    @(negedge clk_in);
    instr_valid_out <= v;
    instr_out <= i;
    dq_out <= d;
    @(posedge clk_in);
  endtask
  // released lines change so a stale word is never mistaken for data
  task automatic idle();
    @(negedge clk_in);
    instr_valid_out <= 1'b0;
    instr_out <= ~instr_out;
    dq_out <= ~dq_out;
  endtask
endmodule // tsh_host_model

// file: testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
  import tsh_pkg::*;
  localparam int DEPTH = 16;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic casc = 1'b0;
  logic chain = 1'b1;
  logic strap = 1'b1;
  logic [4:0] dev_id = 5'h0B;
  int fail_count = 0;
  int tests_run = 0;
  int seed = 63;
  int cyc = 0;
  logic [DQ_W-1:0] ed [DEPTH];
  logic [DQ_W-1:0] em [DEPTH];
  logic [DQ_W-1:0] k;
  logic seen;
  wire phs, vld, dq_oe, ack, ack_oe, bend, bend_oe, flag, win_v;
  wire lhit, lfull, tfull, ctl_oe, oe_oe;
  wire [INSTR_W-1:0] ins;
  wire [DQ_W-1:0] dq, dq_o;
  tsh_sram_s sram;

  always #4 clk_in = ~clk_in;
  tsh_host_model host (.clk_in(clk_in), .phase_select_n_out(phs),
    .instr_out(ins), .instr_valid_out(vld), .dq_out(dq));
  tsh_host_if #(.DEPTH(DEPTH), .ID_W(5)) uut (.clk_in(clk_in),
    .phase_select_n_in(phs), .rstn_in(rstn_in), .instr_in(ins),
    .instr_valid_in(vld), .dq_in(dq), .dq_out(dq_o), .dq_oe_out(dq_oe),
    .read_ack_out(ack), .read_ack_oe_out(ack_oe), .burst_end_out(bend),
    .burst_end_oe_out(bend_oe), .match_win_flag_out(flag),
    .match_win_valid_out(win_v), .device_id_in(dev_id),
    .last_mem_driver_bit_in(strap), .cascade_hit_in(casc),
    .full_chain_in(chain), .local_hit_out(lhit), .local_full_out(lfull),
    .table_full_out(tfull), .sram_out(sram), .sram_ctl_oe_out(ctl_oe),
    .sram_oe_n_oe_out(oe_oe));

  // ****************************************
  // checking helpers
  // ****************************************
  task automatic close_out();
    if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [DQ_W-1:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [8:0] code(input logic [1:0] op, t,
                                     input logic b, input logic [3:0] n);
    return {n, b, t, op};
  endfunction
  // lowest occupied entry whose compared bits equal the key
  function automatic int hit(input logic [DQ_W-1:0] key);
    for (int i = 0; i < DEPTH; i++)
      if (ed[i][OCC_BIT] && ((ed[i] ^ key) & em[i]) === '0) return i;
    return -1;
  endfunction
  task automatic wait_hi(input int w);
    int n;
    n = 0;
    while (n < 40 && (w == 0 ? ack : w == 1 ? win_v : bend) !== 1'b1) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk("wait", n < 40, 1'b1);
  endtask
  task automatic srch(input logic [DQ_W-1:0] key, input logic c);
    int e;
    e = hit(key);
    @(negedge clk_in) casc = c;
    host.send(1'b1, code(2'h2, 2'h0, 1'b0, 4'h0), key);
    host.idle();
    repeat (2) @(posedge clk_in);
    #1 chk("lhit", lhit, e >= 0);
    wait_hi(1);
    chk("flag", flag, e >= 0 && !c);
    chk("oe_n", sram.oe_n, !(e >= 0 || c));
    if (e >= 0 && !c) begin
      chk("assoc_mem_addr", sram.addr, {dev_id, 4'(e)});
      chk("ce_ale", {sram.ce_n, sram.ale_n}, 2'h0);
    end
  endtask
  task automatic xfer(input logic w, input logic [1:0] t,
                      input logic [DQ_W-1:0] w0, w1);
    host.send(1'b1, code({1'b0, w}, t, 1'b1, 4'h1), 68'h2);
    if (w) begin
      host.send(1'b0, 9'($random(seed)), w0);
      host.send(1'b0, 9'($random(seed)), w1);
      host.idle();
      wait_hi(2);
    end else begin
      host.idle();
      wait_hi(0);
      chk("rd0", {dq_o[66:0], bend}, {w0[66:0], 1'b0});
      repeat (2) @(posedge clk_in);
      #1;
      chk("rd1", {dq_o[66:0], bend}, {w1[66:0], 1'b1});
    end
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      ed[i] = '0;
      em[i] = '0;
    end
    repeat (8) @(posedge clk_in);
    #1 chk("rst", {ack, win_v, tfull, dq_oe, sram.ce_n}, 5'h01);
    @(negedge clk_in) rstn_in = 1'b1;
    k = 68'({$random(seed), $random(seed), $random(seed)}) | 68'h1;
    ed[2] = k ^ 68'hF0;
    ed[3] = k;
    em[2] = ~68'hF0;
    em[3] = '1;
    xfer(1'b1, TGT_MASK, em[2], em[3]);
    xfer(1'b1, TGT_DATA, ed[2], ed[3]);
    xfer(1'b0, TGT_MASK, em[2], em[3]);
    xfer(1'b0, TGT_DATA, ed[2], ed[3]);
    srch(k, 1'b0);
    srch(k, 1'b1);
    srch(k ^ 68'h100, 1'b0);
    host.send(1'b0, code(2'h2, 2'h0, 1'b0, 4'h0), k);
    host.idle();
    seen = 1'b0;
    repeat (12) @(posedge clk_in) seen |= win_v;
    chk("novalid", seen, 1'b0);
    for (int n = 0; n < DEPTH - 1; n++) begin
      #1 chk("full", tfull, n == DEPTH - 2);
      k = 68'({$random(seed), $random(seed), $random(seed)}) | 68'h1;
      srch(k, 1'b0);
      host.send(1'b1, code(2'h3, 2'h0, 1'b0, 4'h0), '0);
      host.idle();
      if (n < DEPTH - 2) begin
        for (int i = 0; i < DEPTH; i++)
          if (!ed[i][OCC_BIT] && hit(k) < 0) begin
            ed[i] = k;
            em[i] = '1;
          end
      end
      repeat (6) @(posedge clk_in);
    end
    #1 chk("full", {tfull, lfull}, 2'h3);
    @(negedge clk_in) chain = 1'b0;
    repeat (6) @(posedge clk_in);
    #1 chk("chain", {tfull, lfull}, 2'h1);
    for (int n = 0; n < 20; n++)
      srch(ed[{$random(seed)} % DEPTH], 1'($random(seed)));
    host.send(1'b1, code(2'h1, TGT_SRAM, 1'b0, 4'h0), 68'($random(seed)));
    host.idle();
    repeat (8) @(posedge clk_in);
    host.send(1'b1, code(2'h0, TGT_SRAM, 1'b0, 4'h0), 68'($random(seed)));
    host.idle();
    wait_hi(0);
    chk("sram_rd", dq_oe, 1'b0);
    // second reset with the strap cleared: this device is a plain peer
    @(negedge clk_in);
    rstn_in = 1'b0;
    strap = 1'b0;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in) rstn_in = 1'b1;
    #1 chk("peer", {oe_oe, ctl_oe, lfull, ack}, 4'h0);
    host.send(1'b1, code(2'h0, TGT_SRAM, 1'b0, 4'h0), 68'($random(seed)));
    host.idle();
    seen = 1'b0;
    repeat (12) @(posedge clk_in) seen |= ack;
    chk("peer_ack", seen, 1'b0);
    close_out();
  end
endmodule // testbench

bind tsh_host_if tsh_host_if_assertions #(.DEPTH(DEPTH), .ID_W(ID_W)) chk_i (
  .clk_in(clk_in), .phase_select_n_in(phase_select_n_in),
  .rstn_in(rstn_in), .instr_in(instr_in), .instr_valid_in(instr_valid_in),
  .dq_in(dq_in), .dq_oe_out(dq_oe_out), .read_ack_out(read_ack_out),
  .read_ack_oe_out(read_ack_oe_out), .burst_end_out(burst_end_out),
  .burst_end_oe_out(burst_end_oe_out),
  .match_win_flag_out(match_win_flag_out),
  .match_win_valid_out(match_win_valid_out),
  .last_mem_driver_bit_in(last_mem_driver_bit_in),
  .local_full_out(local_full_out), .table_full_out(table_full_out),
  .sram_out(sram_out), .sram_ctl_oe_out(sram_ctl_oe_out),
  .sram_oe_n_oe_out(sram_oe_n_oe_out));
